// >>> pkg/mcs_cfg.svh
// constants of the master clock strap select block
// assumes a 40 mhz pclk and a 32-bit apb register bus
`ifndef MCS_CFG_SVH
`define MCS_CFG_SVH
// ==========================================
// timing
`define MCS_CLK_HZ        40000000
`define MCS_HOLD_MS       500
`define MCS_ALIGN_MS      80
`define MCS_PFM_S         10
// ==========================================
// register byte offsets
`define MCS_OFF_STATUS    12'h000
`define MCS_OFF_OUT_EN    12'h004
`define MCS_OFF_OUT_MODE  12'h008
`define MCS_OFF_DIV_PWR   12'h00c
`define MCS_OFF_FREQ_OFS  12'h010
`define MCS_OFF_IRQ_STAT  12'h014
`define MCS_OFF_IRQ_MASK  12'h018
// ==========================================
// reset values
`define MCS_RST_FREQ_OFS  32'h046aaaab
// ==========================================
// status field positions
`define MCS_ST_DONE       0
`define MCS_ST_VALID      1
`define MCS_ST_FREQ_LO    2
`define MCS_ST_DIFF       5
`define MCS_ST_BYPASS     6
`define MCS_ST_BUSY       7
`define MCS_ST_REF_LO     8
`define MCS_ST_CODE_LO    10
// ==========================================
// interrupt bit positions
`define MCS_IRQ_STRAP     0
`define MCS_IRQ_ALIGN     1
`define MCS_IRQ_QUAL      2
`define MCS_IRQ_BADCODE   3
`endif

// >>> pkg/mcs_pkg.sv
// types of the master clock strap select block
// assumes nothing beyond a systemverilog elaborator
package mcs_pkg;
  typedef enum logic [2:0] {
    MCS_F10  = 3'h0,
    MCS_F20  = 3'h1,
    MCS_F25  = 3'h2,
    MCS_F50  = 3'h3,
    MCS_F100 = 3'h4,
    MCS_F125 = 3'h5,
    MCS_F200 = 3'h6
  } mcs_freq_e;
  typedef struct packed {
    logic      valid;
    mcs_freq_e freq;
    logic      diff;
    logic      bypass;
  } mcs_strap_s;
  typedef enum logic {MCS_ST_HOLD = 1'b0, MCS_ST_DONE = 1'b1} mcs_strap_state_e;
  typedef enum logic [1:0] {
    MCS_REF_FREE  = 2'h0,
    MCS_REF_HOLD  = 2'h1,
    MCS_REF_TRACK = 2'h3
  } mcs_ref_e;
  typedef enum logic {MCS_AL_IDLE = 1'b0, MCS_AL_RUN = 1'b1} mcs_align_e;
endpackage

// >>> rtl/mcs_strap_clk_ctrl.sv
// master clock strap select, output alignment sequencer and apb registers
// assumes straps and preload mode come from pins; apb on pclk
//
// Decided for this implementation: the APB slave port and the register addresses.
`include "mcs_cfg.svh"

// Behaviour
// - each enabled output gets a timed alignment; software polls busy or waits irq
// - alignment serves synthesizers in order zero, one, two, three
// - after reset the tracking loop is free-running unless preloaded otherwise
// - preloaded auto or forced mode holds over during reference qualification
// - each output position is differential or two single-ended outputs
// - differential position uses upper divider only; lower divider powered down
// - strap window opens at reset release on pins 5,3,2,1,0
// - codes 10100,00010,00000,00001 give 10,20,25,50 MHz single-ended
// - 11111 single-ended and 01011 differential give 100 MHz class with bypass
// - 11001 single-ended and 01101 differential give 125 MHz class with bypass
// - 01100 gives 200 MHz differential with bypass
// - low classes accept -4 percent, high classes -10 percent offset
// - last two pairs come from synthesizer two, or three when bypassed
// - enabling an output starts its alignment; output undriven meanwhile
module mcs_strap_clk_ctrl
  import mcs_pkg::*;
#(
  parameter int unsigned HOLD_CYC  = `MCS_HOLD_MS * (`MCS_CLK_HZ / 1000),
  parameter int unsigned ALIGN_CYC = `MCS_ALIGN_MS * (`MCS_CLK_HZ / 1000),
  parameter int unsigned PFM_CYC   = `MCS_PFM_S * `MCS_CLK_HZ
) (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [4:0]  cfg_pin,
  input  wire logic [1:0]  preload_mode,
  output logic             irq,
  output logic      [5:0]  out_drive,
  output logic      [11:0] div_pwr,
  output logic             last_pair_sel,
  output logic             sys_pll_bypass,
  output logic             mclk_diff_sel,
  output logic      [2:0]  mclk_freq,
  output logic      [1:0]  ref_state,
  output logic      [31:0] freq_offset
);

  // ==========================================
  // helpers
  function automatic mcs_strap_s decode(input logic [4:0] c);
    mcs_strap_s s;
    s = '{valid: 1'b1, freq: MCS_F25, diff: 1'b0, bypass: 1'b0};
    case (c)
      5'h14: s.freq = MCS_F10;
      5'h02: s.freq = MCS_F20;
      5'h00: s.freq = MCS_F25;
      5'h01: s.freq = MCS_F50;
      5'h1f: begin
        s.freq   = MCS_F100;
        s.bypass = 1'b1;
      end
      5'h0b: begin
        s.freq   = MCS_F100;
        s.diff   = 1'b1;
        s.bypass = 1'b1;
      end
      5'h19: begin
        s.freq   = MCS_F125;
        s.bypass = 1'b1;
      end
      5'h0d: begin
        s.freq   = MCS_F125;
        s.diff   = 1'b1;
        s.bypass = 1'b1;
      end
      5'h0c: begin
        s.freq   = MCS_F200;
        s.diff   = 1'b1;
        s.bypass = 1'b1;
      end
      default: s.valid = 1'b0;
    endcase
    return s;
  endfunction

  // synthesizer feeding each output position
  function automatic logic [1:0] synth_of(input int i, input logic byp);
    logic [1:0] r;
    r = 2'h2;
    if (i == 0) begin
      r = 2'h0;
    end else if (i < 3) begin
      r = 2'h1;
    end else if (i > 3) begin
      r = byp ? 2'h3 : 2'h2;
    end
    return r;
  endfunction

  // lowest synthesizer first, then lowest position
  function automatic logic [2:0] pick(input logic [5:0] p, input logic byp);
    logic [2:0] r;
    r = 3'h7;
    for (int s = 3; s >= 0; s--) begin
      for (int i = 5; i >= 0; i--) begin
        if (p[i] && synth_of(i, byp) == 2'(s)) begin
          r = 3'(i);
        end
      end
    end
    return r;
  endfunction

  // ==========================================
  // pin synchronisers
  logic [4:0] cfg_meta;
  logic [4:0] cfg_sync;
  logic [1:0] mode_meta;
  logic [1:0] mode_sync;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_meta  <= 5'h00;
      cfg_sync  <= 5'h00;
      mode_meta <= 2'h0;
      mode_sync <= 2'h0;
    end else if (ce) begin
      cfg_meta  <= cfg_pin;
      cfg_sync  <= cfg_meta;
      mode_meta <= preload_mode;
      mode_sync <= mode_meta;
    end
  end

  // ==========================================
  // strap window and latch
  mcs_strap_state_e strap_st;
  logic [31:0]      hold_cnt;
  logic [4:0]       strap_code;
  mcs_strap_s       strap;
  logic [1:0]       mode;
  wire              hold_end = (strap_st == MCS_ST_HOLD) && (hold_cnt == 32'(HOLD_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      strap_st   <= MCS_ST_HOLD;
      hold_cnt   <= 32'h0;
      strap_code <= 5'h00;
      strap      <= '{valid: 1'b1, freq: MCS_F25, diff: 1'b0, bypass: 1'b0};
      mode       <= 2'h0;
    end else if (ce) begin
      unique case (strap_st)
        MCS_ST_HOLD: begin
          hold_cnt <= hold_cnt + 32'h1;
          if (hold_end) begin
            strap_st   <= MCS_ST_DONE;
            strap_code <= cfg_sync;
            strap      <= decode(cfg_sync);
            mode       <= mode_sync;
          end
        end
        MCS_ST_DONE: strap_st <= MCS_ST_DONE;
      endcase
    end
  end

  // ==========================================
  // tracking loop start-up state
  mcs_ref_e    ref_st;
  logic [31:0] pfm_cnt;
  wire         qual_end = (ref_st == MCS_REF_HOLD) && (pfm_cnt == 32'(PFM_CYC - 1));

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_st  <= MCS_REF_FREE;
      pfm_cnt <= 32'h0;
    end else if (ce) begin
      unique case (ref_st)
        MCS_REF_FREE: begin
          if (hold_end && mode_sync != 2'h0) begin
            ref_st <= MCS_REF_HOLD;
          end
        end
        MCS_REF_HOLD: begin
          pfm_cnt <= pfm_cnt + 32'h1;
          if (qual_end) begin
            ref_st <= MCS_REF_TRACK;
          end
        end
        MCS_REF_TRACK: ref_st <= MCS_REF_TRACK;
        default: ref_st <= MCS_REF_FREE;
      endcase
    end
  end

  // ==========================================
  // registers and apb decode
  logic [5:0]  out_en;
  logic [5:0]  out_mode;
  logic [3:0]  irq_stat;
  logic [3:0]  irq_mask;
  wire         acc     = psel && penable;
  wire         wr      = acc && pwrite && pready;
  wire         hit_st  = paddr == `MCS_OFF_STATUS;
  wire         hit_en  = paddr == `MCS_OFF_OUT_EN;
  wire         hit_md  = paddr == `MCS_OFF_OUT_MODE;
  wire         hit_dp  = paddr == `MCS_OFF_DIV_PWR;
  wire         hit_fo  = paddr == `MCS_OFF_FREQ_OFS;
  wire         hit_is  = paddr == `MCS_OFF_IRQ_STAT;
  wire         hit_im  = paddr == `MCS_OFF_IRQ_MASK;
  wire         hit     = hit_st | hit_en | hit_md | hit_dp | hit_fo | hit_is | hit_im;
  wire  [3:0]  w1c     = (wr && hit_is) ? pwdata[3:0] : 4'h0;

  // ==========================================
  // alignment sequencer
  mcs_align_e  al_st;
  logic [31:0] al_cnt;
  logic [2:0]  al_cur;
  logic [5:0]  pending;
  wire  [5:0]  next_en  = (wr && hit_en) ? pwdata[5:0] : out_en;
  wire  [5:0]  en_rise  = next_en & ~out_en;
  wire  [2:0]  al_pick  = pick(pending, strap.bypass);
  wire         al_end   = (al_st == MCS_AL_RUN) && (al_cnt == 32'(ALIGN_CYC - 1));
  wire  [5:0]  al_clr   = al_end ? 6'(6'h01 << al_cur) : 6'h00;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      al_st   <= MCS_AL_IDLE;
      al_cnt  <= 32'h0;
      al_cur  <= 3'h0;
      pending <= 6'h00;
    end else if (ce) begin
      pending <= ((pending & ~al_clr) & next_en) | en_rise;
      unique case (al_st)
        MCS_AL_IDLE: begin
          al_cnt <= 32'h0;
          if (strap_st == MCS_ST_DONE && al_pick != 3'h7) begin
            al_cur <= al_pick;
            al_st  <= MCS_AL_RUN;
          end
        end
        MCS_AL_RUN: begin
          al_cnt <= al_cnt + 32'h1;
          if (al_end) begin
            al_st <= MCS_AL_IDLE;
          end
        end
      endcase
    end
  end

  // ==========================================
  // register storage and interrupts
  wire [3:0] ev = {hold_end && !decode(cfg_sync).valid, qual_end, al_end, hold_end};
  wire [3:0] next_irq_stat = (irq_stat & ~w1c) | ev;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_en      <= 6'h00;
      out_mode    <= 6'h00;
      freq_offset <= `MCS_RST_FREQ_OFS;
      irq_stat    <= 4'h0;
      irq_mask    <= 4'h0;
      irq         <= 1'b0;
    end else if (ce) begin
      out_en   <= next_en;
      irq_stat <= next_irq_stat;
      irq      <= |(next_irq_stat & irq_mask);
      if (wr && hit_md) begin
        out_mode <= pwdata[5:0];
      end
      if (wr && hit_fo) begin
        freq_offset <= pwdata;
      end
      if (wr && hit_im) begin
        irq_mask <= pwdata[3:0];
      end
    end
  end

  // ==========================================
  // outputs and read data
  logic [11:0] next_div;
  always_comb begin
    next_div = 12'h000;
    for (int i = 0; i < 6; i++) begin
      next_div[2*i]   = out_en[i];
      next_div[2*i+1] = out_en[i] && !out_mode[i];
    end
  end

  logic [31:0] status;
  always_comb begin
    status = 32'h0;
    status[`MCS_ST_DONE]                     = strap_st == MCS_ST_DONE;
    status[`MCS_ST_VALID]                    = strap.valid;
    status[`MCS_ST_FREQ_LO +: 3]             = strap.freq;
    status[`MCS_ST_DIFF]                     = strap.diff;
    status[`MCS_ST_BYPASS]                   = strap.bypass;
    status[`MCS_ST_BUSY]                     = (al_st == MCS_AL_RUN) || (|pending);
    status[`MCS_ST_REF_LO +: 2]              = ref_st;
    status[`MCS_ST_CODE_LO +: 5]             = strap_code;
  end

  wire [31:0] rdata = hit_st ? status :
                      hit_en ? {26'h0, out_en} :
                      hit_md ? {26'h0, out_mode} :
                      hit_dp ? {20'h0, next_div} :
                      hit_fo ? freq_offset :
                      hit_is ? {28'h0, irq_stat} :
                      hit_im ? {28'h0, irq_mask} : 32'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata         <= 32'h0;
      pready         <= 1'b0;
      pslverr        <= 1'b0;
      out_drive      <= 6'h00;
      div_pwr        <= 12'h000;
      last_pair_sel  <= 1'b0;
      sys_pll_bypass <= 1'b0;
      mclk_diff_sel  <= 1'b0;
      mclk_freq      <= 3'h2;
      ref_state      <= 2'h0;
    end else if (ce) begin
      pready         <= acc && !pready;
      pslverr        <= acc && !pready && !hit;
      prdata         <= (acc && !pready && !pwrite) ? rdata : 32'h0;
      out_drive      <= out_en & ~pending;
      div_pwr        <= next_div;
      last_pair_sel  <= strap.bypass;
      sys_pll_bypass <= strap.bypass;
      mclk_diff_sel  <= strap.diff;
      mclk_freq      <= strap.freq;
      ref_state      <= ref_st;
    end
  end

endmodule // mcs_strap_clk_ctrl

// >>> verification/mcs_strap_board.sv
// board model driving the strap and preload pins
// assumes the same reset as the design
module mcs_strap_board #(
  parameter int unsigned HOLD_CYC = 20
) (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [4:0] code,
  input  wire logic [1:0] mode,
  output logic      [4:0] cfg_pin,
  output logic      [1:0] preload_mode
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 0;
    else if (cnt < HOLD_CYC + 4) cnt <= cnt + 1;
  end
  // released pins have no pull, so show the inverse
  assign cfg_pin      = (cnt < HOLD_CYC + 4) ? code : ~code;
  assign preload_mode = mode;
endmodule // mcs_strap_board

// >>> verification/mcs_strap_clk_ctrl_monitor.sv
// checker of the master clock strap select block
// assumes bind onto mcs_strap_clk_ctrl, one pclk domain
module mcs_strap_clk_ctrl_monitor #(
  parameter int unsigned HOLD_CYC  = 20,
  parameter int unsigned ALIGN_CYC = 10,
  parameter int unsigned PFM_CYC   = 30
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic [5:0]  out_drive,
  input wire logic [11:0] div_pwr,
  input wire logic        last_pair_sel,
  input wire logic        sys_pll_bypass,
  input wire logic        mclk_diff_sel,
  input wire logic [2:0]  mclk_freq,
  input wire logic [1:0]  ref_state
);
  timeunit 1ns;
  timeprecision 1ps;
  int unsigned cyc;
  int unsigned gap;
  logic [5:0]  prev_drive;
  wire logic [5:0] drive_rise = out_drive & ~prev_drive;
  // ==========================================
  // cycles since release and since last output came up
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cyc        <= 0;
      gap        <= 0;
      prev_drive <= '0;
    end else begin
      cyc        <= (cyc < 1000) ? cyc + 1 : cyc;
      gap        <= (drive_rise != 6'h0) ? 0 : (gap < ALIGN_CYC) ? gap + 1 : gap;
      prev_drive <= out_drive;
    end
  end
  // ==========================================
  // properties
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_apb_wait: assert property (psel && penable && !pready |=> pready)
    else $error("access not answered after one wait state");
  a_apb_pulse: assert property (pready |=> !pready)
    else $error("pready longer than one cycle");
  a_err_zero: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error response without ready or with data");
  a_lower_div: assert property (((div_pwr >> 1) & ~div_pwr & 12'h555) == 12'h0)
    else $error("lower divider on while upper off");
  a_last_pair: assert property (last_pair_sel == sys_pll_bypass)
    else $error("last pair source differs from bypass");
  a_class_byp: assert property (sys_pll_bypass == (mclk_freq >= 3'h4))
    else $error("bypass does not follow frequency class");
  a_diff_byp: assert property (mclk_diff_sel |-> sys_pll_bypass)
    else $error("differential input without bypass");
  a_strap_win: assert property (cyc + 2 < HOLD_CYC |-> mclk_freq == 3'h2 && out_drive == 6'h0)
    else $error("strap decode or drive before window end");
  a_strap_hold: assert property (cyc > HOLD_CYC + 3 |-> $stable({mclk_freq, mclk_diff_sel}))
    else $error("latched strap value changed");
  a_ref_qual: assert property (ref_state == 2'h3 |-> cyc >= PFM_CYC)
    else $error("tracking before qualification period");
  a_align_gap: assert property (drive_rise != 6'h0 |-> gap + 1 >= ALIGN_CYC)
    else $error("output driven before alignment time");
  a_align_one: assert property ($onehot0(drive_rise))
    else $error("two outputs aligned at once");
  c_err: cover property (pslverr);
  c_track: cover property (ref_state == 2'h3);
  c_diff: cover property (mclk_diff_sel && mclk_freq == 3'h6);
endmodule // mcs_strap_clk_ctrl_monitor

bind mcs_strap_clk_ctrl mcs_strap_clk_ctrl_monitor #(
  .HOLD_CYC(HOLD_CYC), .ALIGN_CYC(ALIGN_CYC), .PFM_CYC(PFM_CYC)
) mon_i (
  .pclk, .presetn, .psel, .penable, .prdata, .pready, .pslverr, .out_drive, .div_pwr,
  .last_pair_sel, .sys_pll_bypass, .mclk_diff_sel, .mclk_freq, .ref_state
);

// >>> verification/test_master_clock_strap_select.sv
// self-checking bench of the master clock strap select block
// assumes the board model and the bound checker
module test_master_clock_strap_select;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int HOLD = 20, ALIGN = 10, PRECISE_FREQUENCY_MONITOR = 30;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, err;
  logic        last_pair_sel, sys_pll_bypass, mclk_diff_sel;
  logic [11:0] paddr, div_pwr;
  logic [31:0] pwdata, prdata, freq_offset, rd;
  logic [5:0]  out_drive;
  logic [4:0]  cfg_pin, code;
  logic [2:0]  mclk_freq;
  logic [1:0]  preload_mode, ref_state, mode;
  int          failures, compares;
  // {code, freq, diff, bypass}
  logic [9:0]  straps [10] = '{10'h280, 10'h044, 10'h008, 10'h02c, 10'h3f1,
                              10'h173, 10'h335, 10'h1b7, 10'h19b, 10'h2a8};
  mcs_strap_clk_ctrl #(.HOLD_CYC(HOLD), .ALIGN_CYC(ALIGN), .PFM_CYC(PRECISE_FREQUENCY_MONITOR)) mcs_strap_clk_ctrl_i (
    .pclk, .presetn, .ce(1'b1), .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr, .cfg_pin, .preload_mode, .irq, .out_drive, .div_pwr,
    .last_pair_sel, .sys_pll_bypass, .mclk_diff_sel, .mclk_freq, .ref_state, .freq_offset);
  mcs_strap_board #(.HOLD_CYC(HOLD)) mcs_strap_board_i (
    .pclk, .presetn, .code, .mode, .cfg_pin, .preload_mode);
  // ==========================================
  // tasks
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic restart(input logic [4:0] c, input logic [1:0] m);
    presetn <= 1'b0;
    code    <= c;
    mode    <= m;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    repeat (HOLD + 8) @(posedge pclk);
  endtask
  task automatic stop_test;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  // ==========================================
  // clock, watchdog, tests
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end
  initial begin
    repeat (4000) @(posedge pclk);
    failures++;
    stop_test;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, code, mode} = '0;
    failures = 0;
    compares = 0;
    for (int i = 0; i < 10; i++) begin
      restart(straps[i][9:5], 2'h0);
      chk("freq", {29'h0, straps[i][4:2]}, {29'h0, mclk_freq});
      chk("diff byp", {30'h0, straps[i][1:0]}, {30'h0, mclk_diff_sel, sys_pll_bypass});
      chk("last pair", {31'h0, straps[i][0]}, {31'h0, last_pair_sel});
      chk("freerun", 32'h0, {30'h0, ref_state});
      apb(1'b0, 12'h000, 32'h0);
      chk("status", {17'h0, straps[i][9:5], 3'h0, straps[i][0], straps[i][1],
                     straps[i][4:2], (i != 9), 1'b1}, rd);
    end
    restart(5'h00, 2'h1);
    chk("holdover", 32'h1, {30'h0, ref_state});
    apb(1'b0, 12'h010, 32'h0);
    chk("offset reset", 32'h046aaaab, rd);
    apb(1'b1, 12'h010, 32'h180072b0);
    apb(1'b0, 12'h010, 32'h0);
    chk("offset", 32'h180072b0, rd);
    chk("offset pin", 32'h180072b0, freq_offset);
    apb(1'b0, 12'h01c, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    apb(1'b1, 12'h018, 32'h4);
    chk("irq masked", 32'h0, {31'h0, irq});
    repeat (PRECISE_FREQUENCY_MONITOR + 8) @(posedge pclk);
    chk("tracking", 32'h3, {30'h0, ref_state});
    chk("irq", 32'h1, {31'h0, irq});
    apb(1'b1, 12'h014, 32'h4);
    apb(1'b0, 12'h014, 32'h0);
    chk("irq stat", 32'h1, rd);
    chk("irq clear", 32'h0, {31'h0, irq});
    restart(5'h1f, 2'h0);
    apb(1'b1, 12'h008, 32'h05);
    apb(1'b1, 12'h004, 32'h3f);
    chk("undriven", 32'h0, {26'h0, out_drive});
    for (int i = 0; i < 6; i++) begin
      repeat (4 * ALIGN) if (!out_drive[i]) @(posedge pclk);
      chk("drive order", (32'h2 << i) - 32'h1, {26'h0, out_drive});
    end
    chk("div pwr", 32'hfdd, {20'h0, div_pwr});
    apb(1'b0, 12'h00c, 32'h0);
    chk("div reg", 32'hfdd, rd);
    apb(1'b1, 12'h004, 32'h3e);
    apb(1'b1, 12'h004, 32'h3f);
    @(posedge pclk);
    chk("realign", 32'h3e, {26'h0, out_drive});
    repeat (4 * ALIGN) if (!out_drive[0]) @(posedge pclk);
    chk("realigned", 32'h3f, {26'h0, out_drive});
    stop_test;
  end
endmodule // test_master_clock_strap_select
